/* hdl/cowd_pkg.sv */
package cowd_pkg;

  localparam int          DATA_W         = 32;
  localparam int          ADDR_W         = 12;
  localparam int          WORD_W         = 13;
  localparam int          NUM_WORDS      = 3;

  // apb byte offsets
  localparam logic [11:0] OFS_WORD0      = 12'h000;
  localparam logic [11:0] OFS_WORD1      = 12'h004;
  localparam logic [11:0] OFS_WORD2      = 12'h008;
  localparam logic [11:0] OFS_STATUS     = 12'h00c;

  // option word 0 field positions
  localparam int          BIT_PERIOD     = 8;
  localparam int          BIT_WDT_OFF    = 7;
  localparam int          BIT_JUMP       = 6;
  localparam int          BIT_CLK_SRC    = 4;
  localparam int          BIT_POWER      = 3;
  localparam int          PROT_LSB       = 0;
  localparam int          PROT_W         = 3;
  localparam logic [2:0]  PROT_OPEN      = 3'h7;
  // content of a store never programmed
  localparam logic [12:0] ERASED_WORD    = 13'h1fff;

  // status register field positions
  localparam int          STAT_OPT_LSB   = 0;
  localparam int          STAT_VALID_BIT = 8;

  // oscillator periods per instruction cycle
  localparam int          DIV_SHORT      = 2;
  localparam int          DIV_LONG       = 4;

  typedef struct packed {
    logic instr_period_sel;
    logic watchdog_off_sel;
    logic jump_cycle_sel;
    logic clock_source_sel;
    logic drive_power_sel;
    logic write_protect_en;
  } cowd_opt_t;

  // protected until the first capture
  localparam cowd_opt_t   OPT_RESET      = 6'h01;

  typedef enum logic [1:0] {
    ST_RESET   = 2'b00,
    ST_CAPTURE = 2'b01,
    ST_RUN     = 2'b11
  } cowd_state_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [11:0]       paddr;
    logic [31:0]       pwdata;
  } cowd_apb_req_t;

  typedef struct packed {
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } cowd_apb_rsp_t;

endpackage

/* hdl/cowd_decode.sv */
`timescale 1ns/100ps
`default_nettype none
module cowd_decode (
  input  wire logic [12:0]         word,
  output cowd_pkg::cowd_opt_t      opt
);

  // bits 12 to 9 and bit 5 are not looked at
  assign opt.instr_period_sel = word[cowd_pkg::BIT_PERIOD];
  assign opt.watchdog_off_sel = word[cowd_pkg::BIT_WDT_OFF];
  assign opt.jump_cycle_sel   = word[cowd_pkg::BIT_JUMP];
  assign opt.clock_source_sel = word[cowd_pkg::BIT_CLK_SRC];
  assign opt.drive_power_sel  = word[cowd_pkg::BIT_POWER];
  assign opt.write_protect_en =
    (word[cowd_pkg::PROT_LSB +: cowd_pkg::PROT_W] != cowd_pkg::PROT_OPEN);

endmodule // cowd_decode
`default_nettype wire

/* hdl/cowd_div.sv */
`timescale 1ns/100ps
`default_nettype none
module cowd_div #(
  parameter int MAXDIV = cowd_pkg::DIV_LONG
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  input  wire logic div_long,
  output logic      tick
);

  localparam int CW = $clog2(MAXDIV);

  localparam logic [CW-1:0] LAST_SHORT = CW'(cowd_pkg::DIV_SHORT - 1);
  localparam logic [CW-1:0] LAST_LONG  = CW'(cowd_pkg::DIV_LONG - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } cowd_div_state_t;

  cowd_div_state_t cur;
  cowd_div_state_t next_cur;
  logic [CW-1:0]   last;

  always_comb
  begin
    next_cur      = cur;
    last          = div_long ? LAST_LONG : LAST_SHORT;
    next_cur.tick = 1'b0;
    if (!run)
    begin
      next_cur.cnt = '0;
    end
    else if (cur.cnt >= last)
    begin
      next_cur.cnt  = '0;
      next_cur.tick = 1'b1;
    end
    else
    begin
      next_cur.cnt = cur.cnt + CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign tick = cur.tick;

endmodule // cowd_div
`default_nettype wire

/* hdl/cowd_top.sv */
// Operation
// - option words live in their own store, apart from program memory
// - the running program has no path to read or change option bits
// - bit 8 selects two or four oscillator periods per instruction cycle
// - bit 7 low enables the watchdog, high disables it
// - bit 6 selects one or two cycles for jump and call
// - bit 4 selects RC clock when low, crystal when high
// - bit 3 selects low power when low, high power when high
// - protection is off only when bits 2 to 0 are all ones
// - bits 12 to 9 of word 0 are ignored
// - words 1 and 2 hold a 13-bit customer id with no effect
// - four-period mode feeds the timer counter oscillator divided by four
`timescale 1ns/100ps
`default_nettype none
module cowd_top (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    prog_en,
  input  wire cowd_pkg::cowd_apb_req_t apb_req,
  output cowd_pkg::cowd_apb_rsp_t      apb_rsp,
  output cowd_pkg::cowd_opt_t          opt,
  output logic [12:0]                  customer_id1,
  output logic [12:0]                  customer_id2,
  output logic                         options_valid,
  output logic                         instr_tick,
  output logic                         timer_tick
);

  typedef struct packed {
    cowd_pkg::cowd_state_t   state;
    cowd_pkg::cowd_opt_t     opt;
    logic [12:0]             id1;
    logic [12:0]             id2;
    cowd_pkg::cowd_apb_rsp_t rsp;
    logic                    valid;
  } cowd_top_state_t;

  cowd_top_state_t     cur;
  cowd_top_state_t     next_cur;
  cowd_pkg::cowd_opt_t dec_opt;
  // erased until the programmer writes it
  logic [12:0]         opt_mem [cowd_pkg::NUM_WORDS] = '{default: cowd_pkg::ERASED_WORD};
  logic                setup;
  logic                access;
  logic                is_word;
  logic [1:0]          word_idx;
  logic                wr_take;
  logic                run;
  logic [31:0]         stat;

  // non-volatile store, reachable only over the programming bus
  always @(posedge pclk)
  begin
    if (wr_take)
    begin
      opt_mem[word_idx] <= apb_req.pwdata[12:0];
    end
  end

  cowd_decode u_decode (
    .word (opt_mem[0]),
    .opt  (dec_opt)
  );

  assign setup    = apb_req.psel && !apb_req.penable;
  assign access   = apb_req.psel && apb_req.penable && cur.rsp.pready;
  assign word_idx = apb_req.paddr[3:2];
  assign is_word  = (apb_req.paddr == cowd_pkg::OFS_WORD0) ||
                    (apb_req.paddr == cowd_pkg::OFS_WORD1) ||
                    (apb_req.paddr == cowd_pkg::OFS_WORD2);
  // writes only with the programmer attached
  assign wr_take  = access && apb_req.pwrite && is_word && prog_en;
  assign run      = (cur.state == cowd_pkg::ST_RUN);

  always_comb
  begin
    next_cur             = cur;
    stat                 = '0;
    stat[cowd_pkg::STAT_OPT_LSB +: 6] = cur.opt;
    stat[cowd_pkg::STAT_VALID_BIT]    = run;
    next_cur.rsp.pready  = 1'b0;
    // capture once per reset, then hold
    case (cur.state)
      cowd_pkg::ST_RESET:
      begin
        next_cur.state = cowd_pkg::ST_CAPTURE;
      end
      cowd_pkg::ST_CAPTURE:
      begin
        next_cur.state = cowd_pkg::ST_RUN;
        next_cur.opt   = dec_opt;
        next_cur.id1   = opt_mem[1];
        next_cur.id2   = opt_mem[2];
        next_cur.valid = 1'b1;
      end
      cowd_pkg::ST_RUN:
      begin
        next_cur.state = cowd_pkg::ST_RUN;
      end
      default:
      begin
        next_cur.state = cowd_pkg::ST_RESET;
      end
    endcase
    if (setup)
    begin
      next_cur.rsp.pready  = 1'b1;
      next_cur.rsp.pslverr = 1'b0;
      next_cur.rsp.prdata  = '0;
      if (is_word)
      begin
        if (apb_req.pwrite)
        begin
          next_cur.rsp.pslverr = !prog_en;
        end
        else if (!prog_en || cur.opt.write_protect_en)
        begin
          next_cur.rsp.pslverr = 1'b1;
        end
        else
        begin
          next_cur.rsp.prdata = {19'h0, opt_mem[word_idx]};
        end
      end
      else if (apb_req.paddr == cowd_pkg::OFS_STATUS)
      begin
        next_cur.rsp.pslverr = apb_req.pwrite;
        next_cur.rsp.prdata  = apb_req.pwrite ? 32'h0 : stat;
      end
      else
      begin
        next_cur.rsp.pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur.state <= cowd_pkg::ST_RESET;
      cur.opt   <= cowd_pkg::OPT_RESET;
      cur.id1   <= '0;
      cur.id2   <= '0;
      cur.rsp   <= '0;
      cur.valid <= 1'b0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // instruction cycle rate from bit 8
  cowd_div #(
    .MAXDIV (cowd_pkg::DIV_LONG)
  ) u_instr_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (run),
    .div_long (cur.opt.instr_period_sel),
    .tick     (instr_tick)
  );

  // timer counter clock follows the same division
  cowd_div #(
    .MAXDIV (cowd_pkg::DIV_LONG)
  ) u_timer_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (run),
    .div_long (cur.opt.instr_period_sel),
    .tick     (timer_tick)
  );

  assign apb_rsp       = cur.rsp;
  assign opt           = cur.opt;
  assign customer_id1  = cur.id1;
  assign customer_id2  = cur.id2;
  assign options_valid = cur.valid;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_hold_opt;
    run |=> $stable(opt) && $stable(customer_id1) && $stable(customer_id2);
  endproperty
  a_hold_opt: assert property (p_hold_opt) else $error("options moved after capture");

  property p_capture_seq;
    cur.state == cowd_pkg::ST_RESET |=> cur.state == cowd_pkg::ST_CAPTURE ##1 run;
  endproperty
  a_capture_seq: assert property (p_capture_seq) else $error("capture sequence broken");

  property p_period;
    cur.state == cowd_pkg::ST_CAPTURE |=>
      opt.instr_period_sel == $past(opt_mem[0][cowd_pkg::BIT_PERIOD]);
  endproperty
  a_period: assert property (p_period) else $error("period select not bit 8");

  property p_wdt;
    cur.state == cowd_pkg::ST_CAPTURE |=>
      opt.watchdog_off_sel == $past(opt_mem[0][cowd_pkg::BIT_WDT_OFF]);
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog select not bit 7");

  property p_jump;
    cur.state == cowd_pkg::ST_CAPTURE |=>
      opt.jump_cycle_sel == $past(opt_mem[0][cowd_pkg::BIT_JUMP]);
  endproperty
  a_jump: assert property (p_jump) else $error("jump select not bit 6");

  property p_clk_src;
    cur.state == cowd_pkg::ST_CAPTURE |=>
      opt.clock_source_sel == $past(opt_mem[0][cowd_pkg::BIT_CLK_SRC]);
  endproperty
  a_clk_src: assert property (p_clk_src) else $error("clock source not bit 4");

  property p_power;
    cur.state == cowd_pkg::ST_CAPTURE |=>
      opt.drive_power_sel == $past(opt_mem[0][cowd_pkg::BIT_POWER]);
  endproperty
  a_power: assert property (p_power) else $error("power select not bit 3");

  property p_protect;
    cur.state == cowd_pkg::ST_CAPTURE |=>
      opt.write_protect_en == ($past(opt_mem[0][2:0]) != cowd_pkg::PROT_OPEN);
  endproperty
  a_protect: assert property (p_protect) else $error("protect decode wrong");

  property p_ids;
    cur.state == cowd_pkg::ST_CAPTURE |=>
      customer_id1 == $past(opt_mem[1]) && customer_id2 == $past(opt_mem[2]);
  endproperty
  a_ids: assert property (p_ids) else $error("customer id not captured");

  property p_no_prog_write;
    setup && apb_req.pwrite && is_word && !prog_en |=> apb_rsp.pready && apb_rsp.pslverr;
  endproperty
  a_no_prog_write: assert property (p_no_prog_write) else $error("write without programmer");

  property p_tick_long;
    timer_tick && opt.instr_period_sel |=> !timer_tick [*3] ##1 timer_tick;
  endproperty
  a_tick_long: assert property (p_tick_long) else $error("timer tick not every 4");

  property p_tick_short;
    instr_tick && !opt.instr_period_sel |=> !instr_tick ##1 instr_tick;
  endproperty
  a_tick_short: assert property (p_tick_short) else $error("instr tick not every 2");

  property p_answer;
    setup |=> apb_rsp.pready ##1 !apb_rsp.pready;
  endproperty
  a_answer: assert property (p_answer) else $error("apb answer timing");

  property p_prot_read;
    setup && !apb_req.pwrite && is_word && cur.opt.write_protect_en |=>
      apb_rsp.pslverr && (apb_rsp.prdata == 32'h0);
  endproperty
  a_prot_read: assert property (p_prot_read) else $error("protected word readable");

  property p_unmapped;
    setup && !is_word && (apb_req.paddr != cowd_pkg::OFS_STATUS) |=> apb_rsp.pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");

  property p_status_wr;
    setup && apb_req.pwrite && (apb_req.paddr == cowd_pkg::OFS_STATUS) |=> apb_rsp.pslverr;
  endproperty
  a_status_wr: assert property (p_status_wr) else $error("status write accepted");

  property p_closed_store;
    access && !prog_en |=>
      $stable(opt_mem[0]) && $stable(opt_mem[1]) && $stable(opt_mem[2]);
  endproperty
  a_closed_store: assert property (p_closed_store) else $error("closed store written");

  property p_ticks_idle;
    !run |-> !instr_tick && !timer_tick;
  endproperty
  a_ticks_idle: assert property (p_ticks_idle) else $error("tick before capture");

  property p_ticks_same;
    instr_tick == timer_tick;
  endproperty
  a_ticks_same: assert property (p_ticks_same) else $error("timer rate differs");

  property p_valid_hold;
    options_valid |=> options_valid;
  endproperty
  a_valid_hold: assert property (p_valid_hold) else $error("valid dropped without reset");

  c_run:        cover property (cur.state == cowd_pkg::ST_CAPTURE ##1 run);
  c_write:      cover property (wr_take);
  c_prot_read:  cover property (setup && !apb_req.pwrite && is_word && opt.write_protect_en);
  c_long_tick:  cover property (timer_tick && opt.instr_period_sel);
  c_short_tick: cover property (instr_tick && !opt.instr_period_sel);

endmodule // cowd_top
`default_nettype wire

/* dv/cowd_prog_model.sv */
`timescale 1ns/100ps
`default_nettype none
module cowd_prog_model (
  input  wire logic                    pclk,
  output var cowd_pkg::cowd_apb_req_t  req,
  input  wire cowd_pkg::cowd_apb_rsp_t rsp
);
  initial req = '0;

  // one transfer: setup, access until pready, then release
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
    begin
      @(posedge pclk);
      req.psel    <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite  <= wr;
      req.paddr   <= addr;
      req.pwdata  <= wdata;
      @(posedge pclk);
      req.penable <= 1'b1;
      @(posedge pclk);
      while (rsp.pready !== 1'b1)
      begin
        @(posedge pclk);
      end
      rdata = rsp.prdata;
      err   = rsp.pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
      // released lines do not keep the last value
      req.paddr   <= ~req.paddr;
      req.pwdata  <= ~req.pwdata;
    end
  endtask

  // option words 0 to 2, 13 bits each
  task automatic put_word(input int idx, input logic [12:0] v, output logic err);
    logic [31:0] d;
    begin
      xfer(1'b1, 12'(idx * 4), {19'h0, v}, d, err);
    end
  endtask
endmodule // cowd_prog_model
`default_nettype wire

/* dv/test_code_option_word_decoder.sv */
`timescale 1ns/100ps
`default_nettype none
module test_code_option_word_decoder;
  typedef struct packed {
    logic [12:0]         word;
    cowd_pkg::cowd_opt_t exp;
  } cowd_row_t;

  logic                    pclk;
  logic                    presetn;
  logic                    prog_en;
  cowd_pkg::cowd_apb_req_t apb_req;
  cowd_pkg::cowd_apb_rsp_t apb_rsp;
  cowd_pkg::cowd_opt_t     opt;
  logic [12:0]             customer_id1;
  logic [12:0]             customer_id2;
  logic                    options_valid;
  logic                    instr_tick;
  logic                    timer_tick;
  logic [31:0]             rd;
  logic                    err;
  int                      fail_count;
  int                      n_tests;
  int                      cyc;
  int                      ni;
  int                      nt;
  cowd_row_t               rows [9] = '{'{13'h1fff, 6'h3e}, '{13'h0000, 6'h01},
    '{13'h0107, 6'h20}, '{13'h0080, 6'h11}, '{13'h0040, 6'h09}, '{13'h0010, 6'h05},
    '{13'h0008, 6'h03}, '{13'h1e26, 6'h01}, '{13'h0003, 6'h01}};

  cowd_top dut_u (.pclk(pclk), .presetn(presetn), .prog_en(prog_en), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .opt(opt), .customer_id1(customer_id1), .customer_id2(customer_id2),
    .options_valid(options_valid), .instr_tick(instr_tick), .timer_tick(timer_tick));
  cowd_prog_model prog_u (.pclk(pclk), .req(apb_req), .rsp(apb_rsp));

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  task automatic give_verdict;
    begin
      if (fail_count == 0 && n_tests > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      n_tests++;
      if (g !== e)
      begin
        $display("unexpected %s: expected %h, seen %h", nm, e, g);
        fail_count++;
      end
    end
  endtask

  task automatic do_reset;
    begin
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      while (options_valid !== 1'b1)
      begin
        @(posedge pclk);
      end
    end
  endtask

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  initial
  begin
    presetn = 1'b0;
    prog_en = 1'b1;
    fail_count = 0;
    n_tests = 0;
    cyc = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    foreach (rows[i])
    begin
      prog_u.put_word(0, rows[i].word, err);
      prog_u.put_word(1, ~rows[i].word, err);
      prog_u.put_word(2, rows[i].word ^ 13'h0aaa, err);
      do_reset();
      chk("opt", 32'(rows[i].exp), 32'(opt));
      chk("id1", {19'h0, ~rows[i].word}, 32'(customer_id1));
      chk("id2", 32'(rows[i].word ^ 13'h0aaa), 32'(customer_id2));
      repeat (8) @(posedge pclk);
      ni = 0;
      nt = 0;
      repeat (16) @(posedge pclk)
      begin
        ni += (instr_tick === 1'b1);
        nt += (timer_tick === 1'b1);
      end
      chk("instr_ticks", rows[i].exp.instr_period_sel ? 4 : 8, ni);
      chk("timer_ticks", rows[i].exp.instr_period_sel ? 4 : 8, nt);
      prog_u.xfer(1'b0, 12'h000, 32'h0, rd, err);
      chk("word0_err", 32'(rows[i].exp.write_protect_en), 32'(err));
      if (!rows[i].exp.write_protect_en)
        chk("word0_rd", 32'(rows[i].word), rd);
    end
    // new contents must not reach opt before a reset
    prog_u.put_word(0, 13'h0100, err);
    repeat (4) @(posedge pclk);
    chk("opt_held", 32'h01, 32'(opt));
    prog_en <= 1'b0;
    prog_u.put_word(0, 13'h0007, err);
    chk("closed_wr_err", 32'h1, 32'(err));
    prog_u.xfer(1'b0, 12'h000, 32'h0, rd, err);
    chk("closed_rd_err", 32'h1, 32'(err));
    prog_en <= 1'b1;
    presetn <= 1'b0;
    @(posedge pclk);
    chk("opt_in_reset", 32'h01, 32'(opt));
    chk("valid_in_reset", 32'h0, 32'(options_valid));
    do_reset();
    chk("opt_after", 32'h21, 32'(opt));
    prog_u.xfer(1'b0, 12'h00c, 32'h0, rd, err);
    chk("status", 32'h121, {23'h0, rd[8:0]});
    prog_u.xfer(1'b1, 12'h00c, 32'h0, rd, err);
    chk("status_wr_err", 32'h1, 32'(err));
    prog_u.xfer(1'b0, 12'h010, 32'h0, rd, err);
    chk("unmapped_err", 32'h1, 32'(err));
    give_verdict();
  end
endmodule // test_code_option_word_decoder
`default_nettype wire
